/* usp_serial_port.sv */
// asynchronous serial port with apb register access
//
// Function
// - frame: start, 5-8 data, parity, stop
// - one stop, two, or 1.5 at five bits
// - 16-bit divisor 1..65535 makes 16x tick
// - receiver runs from same 16x tick
// - offset 0 reads rx, writes tx byte
// - access bit maps divisor onto offsets 0,1
// - divisor low bits 7:0, high 15:8
// - enable bits 0-3 per interrupt source
// - id register: pending low, code, zeros
// - length bits 1:0 give 5 to 8
// - stop count, parity, even, stick bits
// - bit 6 break, bit 7 divisor access
// - modem control bits 0-4, rest zero
// - status ready, overrun, parity, framing, break
// - holding empty, shifter empty, bit7 zero
// - modem delta bits and ring trailing edge
// - modem status current input levels, control bits in loopback
`timescale 1ns/10ps
module usp_serial_port #(
    parameter int ADDR_W = 12
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              ser_in,
    output logic                   ser_out,
    input  wire logic              cts_n,
    input  wire logic              dsr_n,
    input  wire logic              ri_n,
    input  wire logic              dcd_n,
    output logic                   dtr_n,
    output logic                   rts_n,
    output logic                   out1_n,
    output logic                   out2_n,
    output logic                   irq
);
    ////////////////////////////////////////////////////////////////////////////
    // registers and shared signals
    logic [7:0]  dll_r, dlm_r, ier_r, lcr_r, mcr_r, scr_r, rbr_r, thr_r;
    logic        thr_empty_r, dr_r, oe_r, pe_r, fe_r, bi_r;
    logic [3:0]  msr_delta_r, msr_prev_r;
    logic        tick, setup, done, bad_addr, wr, rd;
    logic [2:0]  idx;
    logic [7:0]  rd_data, int_source_id, link_state;
    logic [4:0]  pins_s;
    logic [3:0]  lvl;
    logic [2:0]  len_m1;
    logic [7:0]  len_mask;
    logic [5:0]  stop_len;
    logic        loop;

    assign loop     = mcr_r[usp_pkg::MCR_LOOP];
    assign len_m1   = usp_pkg::LEN_BASE + {1'b0, lcr_r[1:0]};
    assign len_mask = 8'hFF >> (2'h3 - lcr_r[1:0]);
    // half stop only with five-bit characters
    assign stop_len = !lcr_r[usp_pkg::LCR_STOP] ? usp_pkg::STOP_ONE :
                      (lcr_r[1:0] == 2'h0) ? usp_pkg::STOP_ONEHALF : usp_pkg::STOP_TWO;

    ////////////////////////////////////////////////////////////////////////////
    // apb decode: answer in the first access cycle
    assign idx      = paddr[4:2];
    assign bad_addr = (|paddr[ADDR_W-1:5]) | (|paddr[1:0]);
    assign setup    = psel & ~penable;
    assign done     = psel & penable & pready & ~bad_addr;
    assign wr       = done & pwrite;
    assign rd       = done & ~pwrite;

    // ready, error and read data registered in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end else begin
            pready  <= setup;
            pslverr <= setup & bad_addr;
            prdata  <= (setup & ~pwrite & ~bad_addr) ? {24'h000000, rd_data} : 32'h00000000;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // software-written registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {dlm_r, dll_r} <= usp_pkg::DIV_RESET;
            ier_r <= usp_pkg::REG_RESET;
            lcr_r <= usp_pkg::REG_RESET;
            mcr_r <= usp_pkg::REG_RESET;
            scr_r <= usp_pkg::REG_RESET;
            thr_r <= usp_pkg::REG_RESET;
        end else if (wr) begin
            case (idx)
                usp_pkg::IDX_DATA: begin
                    if (lcr_r[usp_pkg::LCR_DIVISOR_ACCESS_SELECT]) dll_r <= pwdata[7:0];
                    else thr_r <= pwdata[7:0];
                end
                usp_pkg::IDX_IER: begin
                    if (lcr_r[usp_pkg::LCR_DIVISOR_ACCESS_SELECT]) dlm_r <= pwdata[7:0];
                    else ier_r <= {4'h0, pwdata[3:0]};
                end
                usp_pkg::IDX_LCR: lcr_r <= pwdata[7:0];
                usp_pkg::IDX_MCR: mcr_r <= {3'h0, pwdata[4:0]};
                usp_pkg::IDX_SCR: scr_r <= pwdata[7:0];
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // baud tick shared by both directions
    usp_baud_gen #(.DIV_W(16)) u_baud (
        .pclk    (pclk),
        .presetn (presetn),
        .divisor ({dlm_r, dll_r}),
        .tick    (tick)
    );

    // serial input and modem inputs brought into the clock domain
    usp_sync2 #(.WIDTH(5), .INIT(5'h1F)) u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .din     ({ser_in, dcd_n, ri_n, dsr_n, cts_n}),
        .dout    (pins_s)
    );

    ////////////////////////////////////////////////////////////////////////////
    // transmitter
    usp_pkg::usp_state_t tx_state_r;
    logic [3:0] tx_sub_r;
    logic [2:0] tx_bit_r;
    logic [5:0] tx_stop_r;
    logic [7:0] tx_shift_r;
    logic       tx_par_r, tx_line, tx_wire, tx_load;

    assign tx_load = tick & (tx_state_r == usp_pkg::ST_IDLE) & ~thr_empty_r;

    // line level of the frame in progress
    always_comb begin
        case (tx_state_r)
            usp_pkg::ST_START: tx_line = 1'b0;
            usp_pkg::ST_DATA:  tx_line = tx_shift_r[0];
            usp_pkg::ST_PAR:   tx_line = tx_par_r;
            default:           tx_line = 1'b1;
        endcase
    end
    assign tx_wire = lcr_r[usp_pkg::LCR_BREAK] ? 1'b0 : tx_line;

    // holding register empty flag; a new write beats the load
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            thr_empty_r <= 1'b1;
        end else begin
            if (tx_load) thr_empty_r <= 1'b1;
            if (wr && idx == usp_pkg::IDX_DATA && !lcr_r[usp_pkg::LCR_DIVISOR_ACCESS_SELECT])
                thr_empty_r <= 1'b0;
        end
    end

    // frame sequencer on the 16x tick
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_state_r <= usp_pkg::ST_IDLE;
            tx_sub_r   <= 4'h0;
            tx_bit_r   <= 3'h0;
            tx_stop_r  <= 6'h00;
            tx_shift_r <= 8'h00;
            tx_par_r   <= 1'b0;
        end else if (tick) begin
            tx_sub_r <= tx_sub_r + 4'h1;
            case (tx_state_r)
                usp_pkg::ST_IDLE: begin
                    tx_sub_r <= 4'h0;
                    if (!thr_empty_r) begin
                        tx_shift_r <= thr_r & len_mask;
                        tx_par_r   <= lcr_r[usp_pkg::LCR_STICK] ? ~lcr_r[usp_pkg::LCR_EVEN] :
                                      (^(thr_r & len_mask)) ^ ~lcr_r[usp_pkg::LCR_EVEN];
                        tx_state_r <= usp_pkg::ST_START;
                    end
                end
                usp_pkg::ST_START: begin
                    tx_bit_r <= 3'h0;
                    if (tx_sub_r == usp_pkg::TICK_LAST) tx_state_r <= usp_pkg::ST_DATA;
                end
                usp_pkg::ST_DATA: begin
                    if (tx_sub_r == usp_pkg::TICK_LAST) begin
                        tx_shift_r <= {1'b0, tx_shift_r[7:1]};
                        tx_bit_r   <= tx_bit_r + 3'h1;
                        tx_stop_r  <= 6'h00;
                        if (tx_bit_r == len_m1)
                            tx_state_r <= lcr_r[usp_pkg::LCR_PAR] ? usp_pkg::ST_PAR
                                                                  : usp_pkg::ST_STOP;
                    end
                end
                usp_pkg::ST_PAR: begin
                    tx_stop_r <= 6'h00;
                    if (tx_sub_r == usp_pkg::TICK_LAST) tx_state_r <= usp_pkg::ST_STOP;
                end
                usp_pkg::ST_STOP: begin
                    tx_stop_r <= tx_stop_r + 6'h01;
                    if (tx_stop_r == stop_len - 6'h01) tx_state_r <= usp_pkg::ST_IDLE;
                end
                default: tx_state_r <= usp_pkg::ST_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // receiver, sampled mid-bit on the same tick
    usp_pkg::usp_state_t rx_state_r;
    logic [3:0] rx_sub_r;
    logic [2:0] rx_bit_r;
    logic [7:0] rx_shift_r, rx_data;
    logic       rx_in, rx_prev_r, rx_par_r, rx_perr_r, rx_pbit_r, rx_done;

    assign rx_in   = loop ? tx_wire : pins_s[4];
    assign rx_data = rx_shift_r >> (3'h7 - len_m1);
    assign rx_done = tick & (rx_state_r == usp_pkg::ST_STOP) & (rx_sub_r == usp_pkg::TICK_LAST);

    // frame sequencer on the 16x tick
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_state_r <= usp_pkg::ST_IDLE;
            rx_sub_r   <= 4'h0;
            rx_bit_r   <= 3'h0;
            rx_shift_r <= 8'h00;
            rx_prev_r  <= 1'b1;
            rx_par_r   <= 1'b0;
            rx_perr_r  <= 1'b0;
            rx_pbit_r  <= 1'b0;
        end else if (tick) begin
            rx_prev_r <= rx_in;
            rx_sub_r  <= rx_sub_r + 4'h1;
            case (rx_state_r)
                usp_pkg::ST_IDLE: begin
                    rx_sub_r <= 4'h0;
                    if (rx_prev_r && !rx_in) rx_state_r <= usp_pkg::ST_START;
                end
                usp_pkg::ST_START: begin
                    rx_bit_r  <= 3'h0;
                    rx_par_r  <= 1'b0;
                    rx_perr_r <= 1'b0;
                    rx_pbit_r <= 1'b0;
                    if (rx_sub_r == usp_pkg::TICK_MID) begin
                        rx_sub_r   <= 4'h0;
                        // a short glitch is not a start bit
                        rx_state_r <= rx_in ? usp_pkg::ST_IDLE : usp_pkg::ST_DATA;
                    end
                end
                usp_pkg::ST_DATA: begin
                    if (rx_sub_r == usp_pkg::TICK_LAST) begin
                        rx_shift_r <= {rx_in, rx_shift_r[7:1]};
                        rx_par_r   <= rx_par_r ^ rx_in;
                        rx_bit_r   <= rx_bit_r + 3'h1;
                        if (rx_bit_r == len_m1)
                            rx_state_r <= lcr_r[usp_pkg::LCR_PAR] ? usp_pkg::ST_PAR
                                                                  : usp_pkg::ST_STOP;
                    end
                end
                usp_pkg::ST_PAR: begin
                    if (rx_sub_r == usp_pkg::TICK_LAST) begin
                        rx_pbit_r  <= rx_in;
                        rx_perr_r  <= lcr_r[usp_pkg::LCR_STICK]
                                      ? (rx_in != ~lcr_r[usp_pkg::LCR_EVEN])
                                      : (rx_in != (rx_par_r ^ ~lcr_r[usp_pkg::LCR_EVEN]));
                        rx_state_r <= usp_pkg::ST_STOP;
                    end
                end
                usp_pkg::ST_STOP: begin
                    if (rx_sub_r == usp_pkg::TICK_LAST) rx_state_r <= usp_pkg::ST_IDLE;
                end
                default: rx_state_r <= usp_pkg::ST_IDLE;
            endcase
        end
    end

    // received byte and line status; a new event beats a read clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rbr_r <= 8'h00;
            dr_r  <= 1'b0;
            oe_r  <= 1'b0;
            pe_r  <= 1'b0;
            fe_r  <= 1'b0;
            bi_r  <= 1'b0;
        end else begin
            if (rd && idx == usp_pkg::IDX_DATA && !lcr_r[usp_pkg::LCR_DIVISOR_ACCESS_SELECT]) dr_r <= 1'b0;
            if (rd && idx == usp_pkg::IDX_LSR) begin
                oe_r <= 1'b0;
                pe_r <= 1'b0;
                fe_r <= 1'b0;
                bi_r <= 1'b0;
            end
            if (rx_done) begin
                rbr_r <= rx_data;
                dr_r  <= 1'b1;
                if (dr_r) oe_r <= 1'b1;
                if (rx_perr_r) pe_r <= 1'b1;
                if (!rx_in) fe_r <= 1'b1;
                if (!rx_in && rx_data == 8'h00 && !rx_pbit_r) bi_r <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // modem status: levels are active-high views of the low pins, or of the control bits in loopback
    assign lvl = loop ? {mcr_r[usp_pkg::MCR_OUT2], mcr_r[usp_pkg::MCR_OUT1],
                         mcr_r[usp_pkg::MCR_DTR], mcr_r[usp_pkg::MCR_RTS]}
                      : ~pins_s[3:0];

    // change flags; a change beats a read clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            msr_prev_r  <= 4'h0;
            msr_delta_r <= 4'h0;
        end else begin
            msr_prev_r <= lvl;
            if (rd && idx == usp_pkg::IDX_MSR) msr_delta_r <= 4'h0;
            // cts, dsr, carrier on any change, ring on falling level
            if (lvl[0] != msr_prev_r[0]) msr_delta_r[0] <= 1'b1;
            if (lvl[1] != msr_prev_r[1]) msr_delta_r[1] <= 1'b1;
            if (msr_prev_r[2] && !lvl[2]) msr_delta_r[2] <= 1'b1;
            if (lvl[3] != msr_prev_r[3]) msr_delta_r[3] <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // interrupt identification and read data
    always_comb begin
        if (ier_r[usp_pkg::IER_LINE] && (oe_r | pe_r | fe_r | bi_r))
            int_source_id = usp_pkg::IIR_LINE;
        else if (ier_r[usp_pkg::IER_RXD] && dr_r)
            int_source_id = usp_pkg::IIR_RXD;
        else if (ier_r[usp_pkg::IER_TX_HOLD_EMPTY_FLAG] && thr_empty_r)
            int_source_id = usp_pkg::IIR_TX_HOLD_EMPTY_FLAG;
        else if (ier_r[usp_pkg::IER_MODEM] && (|msr_delta_r))
            int_source_id = usp_pkg::IIR_MODEM;
        else
            int_source_id = usp_pkg::IIR_NONE;
    end

    // shifter empty only when idle with nothing held
    assign link_state = {1'b0, thr_empty_r & (tx_state_r == usp_pkg::ST_IDLE),
                  thr_empty_r, bi_r, fe_r, pe_r, oe_r, dr_r};

    always_comb begin
        case (idx)
            usp_pkg::IDX_DATA: rd_data = lcr_r[usp_pkg::LCR_DIVISOR_ACCESS_SELECT] ? dll_r : rbr_r;
            usp_pkg::IDX_IER:  rd_data = lcr_r[usp_pkg::LCR_DIVISOR_ACCESS_SELECT] ? dlm_r : ier_r;
            usp_pkg::IDX_IIR:  rd_data = int_source_id;
            usp_pkg::IDX_LCR:  rd_data = lcr_r;
            usp_pkg::IDX_MCR:  rd_data = mcr_r;
            usp_pkg::IDX_LSR:  rd_data = link_state;
            usp_pkg::IDX_MSR:  rd_data = {lvl, msr_delta_r};
            default:           rd_data = scr_r;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // pin outputs; loopback holds the outside lines inactive
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ser_out <= 1'b1;
            dtr_n   <= 1'b1;
            rts_n   <= 1'b1;
            out1_n  <= 1'b1;
            out2_n  <= 1'b1;
            irq     <= 1'b0;
        end else begin
            ser_out <= loop | tx_wire;
            dtr_n   <= loop | ~mcr_r[usp_pkg::MCR_DTR];
            rts_n   <= loop | ~mcr_r[usp_pkg::MCR_RTS];
            out1_n  <= loop | ~mcr_r[usp_pkg::MCR_OUT1];
            out2_n  <= loop | ~mcr_r[usp_pkg::MCR_OUT2];
            irq     <= ~int_source_id[0];
        end
    end
endmodule : usp_serial_port

/* usp_pkg.sv */
// shared constants and types of the asynchronous serial port
package usp_pkg;

    // register indices; the byte address is four times the index
    localparam logic [2:0] IDX_DATA = 3'h0;
    localparam logic [2:0] IDX_IER  = 3'h1;
    localparam logic [2:0] IDX_IIR  = 3'h2;
    localparam logic [2:0] IDX_LCR  = 3'h3;
    localparam logic [2:0] IDX_MCR  = 3'h4;
    localparam logic [2:0] IDX_LSR  = 3'h5;
    localparam logic [2:0] IDX_MSR  = 3'h6;
    localparam logic [2:0] IDX_SCR  = 3'h7;

    // frame_format_control bit positions
    localparam int LCR_STOP  = 2;
    localparam int LCR_PAR   = 3;
    localparam int LCR_EVEN  = 4;
    localparam int LCR_STICK = 5;
    localparam int LCR_BREAK = 6;
    localparam int LCR_DIVISOR_ACCESS_SELECT  = 7;

    // int_enable and modem_output_control bit positions
    localparam int IER_RXD   = 0;
    localparam int IER_TX_HOLD_EMPTY_FLAG  = 1;
    localparam int IER_LINE  = 2;
    localparam int IER_MODEM = 3;
    localparam int MCR_DTR   = 0;
    localparam int MCR_RTS   = 1;
    localparam int MCR_OUT1  = 2;
    localparam int MCR_OUT2  = 3;
    localparam int MCR_LOOP  = 4;

    // reset values
    localparam logic [15:0] DIV_RESET = 16'h000C;
    localparam logic [7:0]  REG_RESET = 8'h00;

    // int_source_id codes
    localparam logic [7:0] IIR_NONE  = 8'h01;
    localparam logic [7:0] IIR_LINE  = 8'h06;
    localparam logic [7:0] IIR_RXD   = 8'h04;
    localparam logic [7:0] IIR_TX_HOLD_EMPTY_FLAG  = 8'h02;
    localparam logic [7:0] IIR_MODEM = 8'h00;

    // sixteenths of a bit, and the data length base
    localparam logic [3:0] TICK_LAST    = 4'hF;
    localparam logic [3:0] TICK_MID     = 4'h7;
    localparam logic [5:0] STOP_ONE     = 6'h10;
    localparam logic [5:0] STOP_ONEHALF = 6'h18;
    localparam logic [5:0] STOP_TWO     = 6'h20;
    localparam logic [2:0] LEN_BASE     = 3'h4;

    // frame sequencer states, gray along the frame
    typedef enum logic [2:0] {
        ST_IDLE  = 3'h0,
        ST_START = 3'h1,
        ST_DATA  = 3'h3,
        ST_PAR   = 3'h2,
        ST_STOP  = 3'h6
    } usp_state_t;

endpackage : usp_pkg

/* usp_sync2.sv */
// two flip-flop synchroniser for a group of levels
`timescale 1ns/10ps
module usp_sync2 #(
    parameter int               WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT  = '0
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic [WIDTH-1:0] din,
    output logic      [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] meta_r;

    // first stage feeds only the second
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_r <= INIT;
            dout   <= INIT;
        end else begin
            meta_r <= din;
            dout   <= meta_r;
        end
    end
endmodule : usp_sync2

/* usp_baud_gen.sv */
// divider that makes the 16x sample tick
`timescale 1ns/10ps
module usp_baud_gen #(
    parameter int DIV_W = 16
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic [DIV_W-1:0] divisor,
    output logic                  tick
);
    logic [DIV_W-1:0] cnt_r;
    logic [DIV_W-1:0] last;

    // a divisor of zero wraps and divides by the full count range
    assign last = divisor - {{(DIV_W-1){1'b0}}, 1'b1};

    // one tick every divisor clocks
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= '0;
            tick  <= 1'b0;
        end else if (cnt_r >= last) begin
            cnt_r <= '0;
            tick  <= 1'b1;
        end else begin
            cnt_r <= cnt_r + {{(DIV_W-1){1'b0}}, 1'b1};
            tick  <= 1'b0;
        end
    end
endmodule : usp_baud_gen

/* usp_assertions.sv */
// checker of apb answers and pin levels of the serial port
`timescale 1ns/10ps
module usp_checker #(
    parameter int ADDR_W = 12
) (
    input wire logic              pclk,
    input wire logic              presetn,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0]       pwdata,
    input wire logic [31:0]       prdata,
    input wire logic              pready,
    input wire logic              ser_out,
    input wire logic              dtr_n,
    input wire logic              rts_n,
    input wire logic              out1_n,
    input wire logic              out2_n,
    input wire logic              irq
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // completed read and write of the current access
    wire rd = psel && penable && pready && !pwrite;
    wire wr = psel && penable && pready && pwrite;
    a_ready_setup: assert property (psel && !penable |=> pready)
        else $error("no answer after setup");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready held");
    a_iir_zeros: assert property (rd && paddr == 'h8 |-> prdata[31:3] == 0)
        else $error("id reserved bits set");
    a_lsr_top: assert property (rd && paddr == 'h14 |-> prdata[31:7] == 0)
        else $error("status bit 7 set");
    // pins follow the control register one clock after the write lands
    a_mcr_pins: assert property (wr && paddr == 'h10 && !pwdata[4]
        |=> ##1 {out2_n, out1_n, rts_n, dtr_n} == ~$past(pwdata[3:0], 2))
        else $error("modem pins");
    a_loop_quiet: assert property (wr && paddr == 'h10 && pwdata[4]
        |=> ##1 &{out2_n, out1_n, rts_n, dtr_n}) else $error("pins active in loop");
    a_reset_idle: assert property ($rose(presetn) |-> ser_out && !irq && !pready)
        else $error("not idle after reset");
    a_irq_quiet: assert property ($rose(presetn) |-> ##1 !irq [*3])
        else $error("irq with all enables clear");
endmodule : usp_checker

bind usp_serial_port usp_checker #(.ADDR_W(ADDR_W)) u_usp_checker (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .ser_out, .dtr_n, .rts_n,
    .out1_n, .out2_n, .irq);

/* usp_remote.sv */
// remote terminal: sends frames to the port and collects its frames
`timescale 1ns/10ps
module usp_remote #(
    parameter int BIT_CLKS = 16
) (
    input  wire logic  pclk,
    input  wire logic  line_in,
    output logic       line_out,
    output logic [7:0] rx_byte,
    output logic [7:0] rx_count
);
    // one start, eight data lsb first, one stop
    task automatic send(input logic [7:0] data);
        logic [9:0] frame;
        frame = {1'b1, data, 1'b0};
        for (int i = 0; i < 10; i++) begin
            line_out <= frame[i];
            repeat (BIT_CLKS) @(posedge pclk);
        end
    endtask : send
    // sample mid cell after a falling start edge
    initial begin
        line_out = 1'b1;
        rx_byte = 8'h00;
        rx_count = 8'h00;
        forever begin
            @(negedge line_in);
            repeat (BIT_CLKS / 2) @(posedge pclk);
            for (int i = 0; i < 8; i++) begin
                repeat (BIT_CLKS) @(posedge pclk);
                rx_byte[i] = line_in;
            end
            repeat (BIT_CLKS) @(posedge pclk);
            rx_count = rx_count + 8'h01;
        end
    end
endmodule : usp_remote

/* tb_top.sv */
// bench: registers, frames both ways, modem, loopback, refusal, break, reset
`timescale 1ns/10ps
module tb_top;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic        ser_in, ser_out, cts_n, dtr_n, rts_n, out1_n, out2_n, irq;
    logic        dsr_n, ri_n, dcd_n;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [7:0]  rx_seen, rx_cnt;
    int          mismatches, checked;
    typedef struct packed {logic [2:0] idx; logic [7:0] wd; logic [7:0] ex;} usp_row_t;
    localparam usp_row_t ROWS [8] = '{'{3'h7, 8'hA5, 8'hA5}, '{3'h7, 8'h5A, 8'h5A},
        '{3'h1, 8'hFF, 8'h0F}, '{3'h4, 8'hE3, 8'h03}, '{3'h3, 8'h83, 8'h83},
        '{3'h0, 8'h01, 8'h01}, '{3'h1, 8'h00, 8'h00}, '{3'h3, 8'h03, 8'h03}};
    usp_serial_port #(.ADDR_W(12)) u_usp_serial_port (.pclk, .presetn, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .ser_in, .ser_out, .cts_n,
        .dsr_n, .ri_n, .dcd_n, .dtr_n, .rts_n, .out1_n, .out2_n, .irq);
    // divisor 1 gives sixteen clocks a bit
    usp_remote #(.BIT_CLKS(16)) u_usp_remote (.pclk, .line_in(ser_out), .line_out(ser_in),
        .rx_byte(rx_seen), .rx_count(rx_cnt));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] ex);
        checked++;
        if (seen !== ex) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", what, ex, seen);
        end
    endtask : check
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rchk(input string what, input logic [2:0] idx, input logic [7:0] ex);
        apb(1'b0, {7'h0, idx, 2'b00}, 8'h00);
        check(what, rd, {24'h0, ex});
    endtask : rchk
    task automatic test_done;
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : test_done
    ////////////////////////////////////////////////////////////////////////////////
    // clock and watchdog
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    initial begin
        #2000000;
        mismatches++;
        test_done();
    end
    // main sequence
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {cts_n, dsr_n, ri_n, dcd_n} = 4'hF;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        foreach (ROWS[i]) begin
            apb(1'b1, {7'h0, ROWS[i].idx, 2'b00}, ROWS[i].wd);
            rchk("reg", ROWS[i].idx, ROWS[i].ex);
        end
        rchk("iir", usp_pkg::IDX_IIR, 8'h02);
        $display("test registers done");
        apb(1'b1, 12'h000, 8'h55);
        for (int n = 0; n < 400 && rx_cnt == 8'h00; n++) @(posedge pclk);
        check("tx byte", {24'h0, rx_seen}, 32'h55);
        repeat (16) @(posedge pclk);
        rchk("lsr", usp_pkg::IDX_LSR, 8'h60);
        check("irq", {31'h0, irq}, 32'h1);
        u_usp_remote.send(8'hA3);
        repeat (4) @(posedge pclk);
        rchk("iir", usp_pkg::IDX_IIR, 8'h04);
        rchk("lsr", usp_pkg::IDX_LSR, 8'h61);
        rchk("rx byte", usp_pkg::IDX_DATA, 8'hA3);
        rchk("lsr", usp_pkg::IDX_LSR, 8'h60);
        $display("test frames done");
        cts_n <= 1'b0;
        repeat (4) @(posedge pclk);
        rchk("msr", usp_pkg::IDX_MSR, 8'h11);
        rchk("msr", usp_pkg::IDX_MSR, 8'h10);
        // ring pulse flags only its trailing edge; carrier flags any change
        ri_n <= 1'b0;
        repeat (4) @(posedge pclk);
        {ri_n, dcd_n} <= 2'b10;
        repeat (4) @(posedge pclk);
        rchk("msr", usp_pkg::IDX_MSR, 8'h9C);
        rchk("msr", usp_pkg::IDX_MSR, 8'h90);
        apb(1'b1, 12'h010, 8'h13);
        repeat (4) @(posedge pclk);
        rchk("msr", usp_pkg::IDX_MSR, 8'h3A);
        apb(1'b1, 12'h000, 8'h3C);
        repeat (220) @(posedge pclk);
        rchk("loop byte", usp_pkg::IDX_DATA, 8'h3C);
        apb(1'b1, 12'h010, 8'h00);
        $display("test modem done");
        apb(1'b1, 12'h01D, 8'hFF);
        check("slverr", {31'h0, err}, 32'h1);
        rchk("scratch", usp_pkg::IDX_SCR, 8'h5A);
        apb(1'b1, 12'h00C, 8'h43);
        repeat (3) @(posedge pclk);
        check("break", {31'h0, ser_out}, 32'h0);
        presetn <= 1'b0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        rchk("lcr", usp_pkg::IDX_LCR, 8'h00);
        rchk("iir", usp_pkg::IDX_IIR, 8'h01);
        rchk("lsr", usp_pkg::IDX_LSR, 8'h60);
        $display("test refusal break reset done");
        test_done();
    end
endmodule : tb_top
